// [hw/smc_defs.svh]
// register addresses, field positions, reset values and timing counts
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

`define SMC_CTRL_ADDR 8'hC0
`define SMC_STATUS_ADDR 8'hC1
`define SMC_PRESET_ADDR 8'hCF

`define SMC_BIT_BUSY 7
`define SMC_BIT_EN 6
`define SMC_BIT_BEGIN 5
`define SMC_BIT_HALT 4
`define SMC_BIT_SI 3
`define SMC_BIT_ACK 2
`define SMC_BIT_FTE 1
`define SMC_BIT_TOE 0

`define SMC_CTRL_RST 8'h00
`define SMC_STATUS_RST 8'hF8
`define SMC_PRESET_RST 8'h00
`define SMC_IDLE_CODE 8'hF8
`define SMC_CODE_MASK 8'hF8

`define SMC_CLK_HZ 25000000
`define SMC_BUS_IDLE_US 50
`define SMC_BUS_IDLE_CYC ((`SMC_BUS_IDLE_US * (`SMC_CLK_HZ / 1000000)))
`define SMC_HIGH_EXTRA_NS 625
`define SMC_HIGH_BASE_CYC 2
`define SMC_HIGH_EXTRA_CYC (`SMC_HIGH_BASE_CYC + \
   ((`SMC_HIGH_EXTRA_NS * (`SMC_CLK_HZ / 1000000) + 999) / 1000))
`define SMC_FREE_ROLLS 10
`define SMC_FREE_TERM 9'h100

`endif

// [hw/smc_pkg.sv]
// types shared by the control and clock-rate logic
package smc_pkg;
   typedef enum logic [2:0] {
      SMC_IDLE = 3'b000,
      SMC_WAIT_FREE = 3'b001,
      SMC_START = 3'b010,
      SMC_CLOCK = 3'b011,
      SMC_RSTART = 3'b100,
      SMC_STOP = 3'b101
   } smc_mst_state_t;
endpackage

// [hw/smc_line_mon.sv]
// line synchroniser and start/stop detector for the two bus wires
`timescale 1ns/10ps
module smc_line_mon (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // raw bus levels
   input wire logic i_scl,
   input wire logic i_sda,
   // synchronised view
   output logic o_scl,
   output logic o_sda,
   output logic o_start_det,
   output logic o_stop_det
);
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic scl_d_ff;
   logic sda_d_ff;
   logic start_ff;
   logic stop_ff;
   logic [1:0] nxt_scl_sync;
   logic [1:0] nxt_sda_sync;
   logic nxt_start;
   logic nxt_stop;

   always_comb begin
      nxt_scl_sync = {scl_sync_ff[0], i_scl};
      nxt_sda_sync = {sda_sync_ff[0], i_sda};
      // only the second stage and its delayed copy feed any decision
      nxt_start = scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_sync_ff[1];
      nxt_stop = scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_sync_ff[1];
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         start_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else begin
         scl_sync_ff <= nxt_scl_sync;
         sda_sync_ff <= nxt_sda_sync;
         scl_d_ff <= scl_sync_ff[1];
         sda_d_ff <= sda_sync_ff[1];
         start_ff <= nxt_start;
         stop_ff <= nxt_stop;
      end
   end

   assign o_scl = scl_d_ff;
   assign o_sda = sda_d_ff;
   assign o_start_det = start_ff;
   assign o_stop_det = stop_ff;
endmodule

// [hw/smc_ctrl.sv]
// control register, bus state and clock-rate generator of the two-wire interface
`timescale 1ns/10ps
`include "smc_defs.svh"

// Functional notes
// - interrupt flag set on any non-idle state
// - hardware never clears the interrupt flag
// - flag plus enable raises interrupt request
// - flag stretches clock low, not high
// - halt flag cleared when stop seen
// - enable off releases lines, drops state
// - begin request: start now or after stop
// - bus free after stop or idle timeout
// - begin after a byte gives repeated start
// - halt in master mode drives stop
// - slave halt simulates stop, bus stays busy
// - both requests: stop first, then start
// - ack slot drives level per ack flag
// - ack flag off ignores own addresses
// - free timer counts high, overflow frees bus
// - low-timeout timer reload high, count low
// - control register layout, busy read-only
// - preset loads up-counter, rollover toggles clock
// - low and high times from preset
// - free timeout ten preset periods
// - status code multiple of eight
module smc_ctrl #(
   parameter int BUS_IDLE_CYC = `SMC_BUS_IDLE_CYC,
   parameter int HIGH_EXTRA_CYC = `SMC_HIGH_EXTRA_CYC,
   parameter int FREE_ROLLS = `SMC_FREE_ROLLS
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // special function register port
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sfr_bit_wr,
   input wire logic [2:0] i_sfr_bit_sel,
   input wire logic i_sfr_bit_val,
   input wire logic i_sfr_rd,
   output logic [7:0] o_sfr_rdata,
   // cpu interrupt
   input wire logic i_irq_en,
   output logic o_irq,
   // bus pins
   input wire logic i_scl,
   output logic o_scl,
   output logic o_scl_oe,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   // shift engine side
   input wire logic i_state_event,
   input wire logic [7:0] i_state_code,
   input wire logic i_byte_done,
   input wire logic i_arb_lost,
   input wire logic i_data_low,
   input wire logic i_ack_slot,
   input wire logic i_addressed,
   output logic o_iface_enable,
   output logic o_master,
   output logic o_start_sent,
   output logic o_sim_stop,
   output logic o_addr_match_en,
   // scl-low timeout timer hook
   output logic o_lt_reload,
   output logic o_lt_count
);
   // counter widths below cap these values
   if (HIGH_EXTRA_CYC < 1 || HIGH_EXTRA_CYC > 31 || FREE_ROLLS < 1 || FREE_ROLLS > 15
       || BUS_IDLE_CYC < 1 || BUS_IDLE_CYC > 2047) begin
      $error("smc_ctrl: timing parameter out of range");
   end

   logic scl_s, sda_s, start_det, stop_det;
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [7:0] preset_ff, nxt_preset;
   logic [7:0] status_ff, nxt_status;
   logic [7:0] rdata_ff, nxt_rdata;
   logic busy_ff, nxt_busy;
   smc_pkg::smc_mst_state_t st_ff, nxt_st;
   logic [7:0] cnt_ff, nxt_cnt;
   logic [4:0] xcnt_ff, nxt_xcnt;
   logic [1:0] step_ff, nxt_step;
   logic scl_drv_ff, nxt_scl_drv;
   logic sda_drv_ff, nxt_sda_drv;
   logic bytes_ff, nxt_bytes;
   logic [8:0] ft_cnt_ff, nxt_ft_cnt;
   logic [3:0] ft_rolls_ff, nxt_ft_rolls;
   logic [10:0] idle_cnt_ff, nxt_idle_cnt;
   logic irq_ff, nxt_irq;
   logic scl_oe_ff, nxt_scl_oe;
   logic sda_oe_ff, nxt_sda_oe;
   logic start_sent_ff, nxt_start_sent;
   logic sim_stop_ff, nxt_sim_stop;
   logic master_ff, nxt_master;
   logic lt_reload_ff, nxt_lt_reload;
   logic lt_count_ff, nxt_lt_count;
   logic [7:0] wmask;
   logic [7:0] wval;
   logic en, roll, free_tmo;

   smc_line_mon u_line_mon (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_scl(scl_s),
      .o_sda(sda_s),
      .o_start_det(start_det),
      .o_stop_det(stop_det)
   );

   assign en = ctrl_ff[`SMC_BIT_EN];
   assign roll = (cnt_ff == 8'hFF);

   // register writes, byte-wide or single bit
   always_comb begin
      wmask = 8'h00;
      wval = i_sfr_wdata;
      if (i_sfr_wr && i_sfr_addr == `SMC_CTRL_ADDR) begin
         wmask = 8'h7F;
      end else if (i_sfr_bit_wr && i_sfr_addr == `SMC_CTRL_ADDR
                   && i_sfr_bit_sel != 3'(`SMC_BIT_BUSY)) begin
         wmask = 8'h01 << i_sfr_bit_sel;
         wval = {8{i_sfr_bit_val}};
      end
   end

   // bus-free timing
   always_comb begin
      nxt_ft_cnt = {1'b0, preset_ff};
      nxt_ft_rolls = 4'h0;
      nxt_idle_cnt = 11'h000;
      free_tmo = 1'b0;
      if (en && scl_s && sda_s && busy_ff) begin
         nxt_idle_cnt = idle_cnt_ff + 11'h001;
         if (idle_cnt_ff == 11'(BUS_IDLE_CYC - 1)) begin
            free_tmo = 1'b1;
         end
         if (ctrl_ff[`SMC_BIT_FTE]) begin
            nxt_ft_rolls = ft_rolls_ff;
            nxt_ft_cnt = ft_cnt_ff + 9'h001;
            if (ft_cnt_ff == `SMC_FREE_TERM) begin
               // each roll is (256 - preset) + 1 cycles
               nxt_ft_cnt = {1'b0, preset_ff};
               nxt_ft_rolls = ft_rolls_ff + 4'h1;
               if (ft_rolls_ff == 4'(FREE_ROLLS - 1)) begin
                  free_tmo = 1'b1;
               end
            end
         end
      end
      nxt_busy = busy_ff;
      if (start_det) begin
         nxt_busy = 1'b1;
      end else if (stop_det || free_tmo) begin
         nxt_busy = 1'b0;
      end
      if (!en) begin
         nxt_busy = 1'b0;
      end
   end

   // control, status and preset registers
   always_comb begin
      nxt_ctrl = (ctrl_ff & ~wmask) | (wval & wmask);
      nxt_ctrl[`SMC_BIT_BUSY] = busy_ff;
      // a software write of the halt bit beats the hardware clear
      if (stop_det && !wmask[`SMC_BIT_HALT]) begin
         nxt_ctrl[`SMC_BIT_HALT] = 1'b0;
      end
      if (sim_stop_ff && !wmask[`SMC_BIT_HALT]) begin
         nxt_ctrl[`SMC_BIT_HALT] = 1'b0;
      end
      nxt_status = status_ff;
      // set beats a clear written in the same cycle
      if (en && i_state_event && i_state_code != `SMC_IDLE_CODE) begin
         nxt_ctrl[`SMC_BIT_SI] = 1'b1;
         nxt_status = i_state_code & `SMC_CODE_MASK;
      end
      nxt_preset = preset_ff;
      if (i_sfr_wr && i_sfr_addr == `SMC_PRESET_ADDR) begin
         nxt_preset = i_sfr_wdata;
      end
      nxt_rdata = rdata_ff;
      if (i_sfr_rd) begin
         unique case (i_sfr_addr)
            `SMC_CTRL_ADDR: nxt_rdata = ctrl_ff;
            `SMC_STATUS_ADDR: nxt_rdata = status_ff;
            `SMC_PRESET_ADDR: nxt_rdata = preset_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
      nxt_irq = ctrl_ff[`SMC_BIT_SI] && i_irq_en;
   end

   // master sequencer and scl generator
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff + 8'h01;
      nxt_xcnt = 5'h00;
      nxt_step = step_ff;
      nxt_scl_drv = scl_drv_ff;
      nxt_sda_drv = sda_drv_ff;
      nxt_start_sent = 1'b0;
      nxt_sim_stop = 1'b0;
      nxt_bytes = bytes_ff || i_byte_done;
      unique case (st_ff)
         smc_pkg::SMC_IDLE: begin
            nxt_cnt = preset_ff;
            nxt_step = 2'h0;
            if (ctrl_ff[`SMC_BIT_HALT] && !sim_stop_ff) begin
               nxt_sim_stop = 1'b1;
            end else if (ctrl_ff[`SMC_BIT_BEGIN]) begin
               nxt_st = smc_pkg::SMC_WAIT_FREE;
            end
         end
         smc_pkg::SMC_WAIT_FREE: begin
            // free bus on entry starts at once, else wait one preset period
            if (busy_ff) begin
               nxt_cnt = preset_ff;
               nxt_step = 2'h1;
            end else if (step_ff == 2'h0 || roll) begin
               nxt_st = smc_pkg::SMC_START;
               nxt_sda_drv = 1'b1;
               nxt_cnt = preset_ff;
            end
         end
         smc_pkg::SMC_START: begin
            if (roll) begin
               nxt_st = smc_pkg::SMC_CLOCK;
               nxt_scl_drv = 1'b1;
               nxt_cnt = preset_ff;
               nxt_start_sent = 1'b1;
               nxt_bytes = 1'b0;
            end
         end
         smc_pkg::SMC_CLOCK: begin
            nxt_sda_drv = 1'b0;
            if (scl_drv_ff) begin
               if (ctrl_ff[`SMC_BIT_SI]) begin
                  nxt_cnt = cnt_ff;
               end else if (roll) begin
                  nxt_cnt = preset_ff;
                  nxt_step = 2'h0;
                  if (ctrl_ff[`SMC_BIT_HALT]) begin
                     nxt_st = smc_pkg::SMC_STOP;
                     nxt_sda_drv = 1'b1;
                  end else if (ctrl_ff[`SMC_BIT_BEGIN] && bytes_ff) begin
                     nxt_st = smc_pkg::SMC_RSTART;
                  end else begin
                     nxt_scl_drv = 1'b0;
                  end
               end
            end else if (!scl_s) begin
               nxt_cnt = cnt_ff; // another device still holds the clock low
            end else if (roll) begin
               nxt_cnt = cnt_ff;
               nxt_xcnt = xcnt_ff + 5'h01;
               if (xcnt_ff == 5'(HIGH_EXTRA_CYC - 1)) begin
                  nxt_scl_drv = 1'b1;
                  nxt_cnt = preset_ff;
               end
            end
         end
         smc_pkg::SMC_RSTART: begin
            // release data low, raise clock, then pull data for the start
            if (roll) begin
               nxt_cnt = preset_ff;
               if (step_ff == 2'h0) begin
                  nxt_scl_drv = 1'b0;
                  nxt_step = 2'h1;
               end else if (scl_s) begin
                  nxt_sda_drv = 1'b1;
                  nxt_st = smc_pkg::SMC_START;
               end else begin
                  nxt_cnt = cnt_ff;
               end
            end
         end
         smc_pkg::SMC_STOP: begin
            if (roll) begin
               nxt_cnt = preset_ff;
               if (step_ff == 2'h0) begin
                  nxt_scl_drv = 1'b0;
                  nxt_step = 2'h1;
               end else if (scl_s) begin
                  nxt_sda_drv = 1'b0;
                  nxt_step = 2'h0;
                  // begin still pending goes round for a fresh start
                  nxt_st = ctrl_ff[`SMC_BIT_BEGIN] ? smc_pkg::SMC_WAIT_FREE
                                                   : smc_pkg::SMC_IDLE;
               end else begin
                  nxt_cnt = cnt_ff;
               end
            end
         end
         default: begin
            nxt_st = smc_pkg::SMC_IDLE;
         end
      endcase
      if (i_arb_lost) begin
         nxt_st = smc_pkg::SMC_IDLE;
         nxt_scl_drv = 1'b0;
         nxt_sda_drv = 1'b0;
      end
      if (!en) begin
         nxt_st = smc_pkg::SMC_IDLE;
         nxt_scl_drv = 1'b0;
         nxt_sda_drv = 1'b0;
         nxt_step = 2'h0;
         nxt_bytes = 1'b0;
         nxt_sim_stop = 1'b0;
      end
      nxt_master = (nxt_st != smc_pkg::SMC_IDLE);
   end

   // pin drives and timer hook
   always_comb begin
      // stretch only once the line is already low
      nxt_scl_oe = en && (scl_drv_ff || (ctrl_ff[`SMC_BIT_SI] && !scl_s));
      nxt_sda_oe = en && (sda_drv_ff
                   || (st_ff == smc_pkg::SMC_CLOCK && i_data_low && !i_ack_slot)
                   || (i_ack_slot && i_addressed && ctrl_ff[`SMC_BIT_ACK]));
      nxt_lt_reload = en && ctrl_ff[`SMC_BIT_TOE] && scl_s;
      nxt_lt_count = en && ctrl_ff[`SMC_BIT_TOE] && !scl_s;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         ctrl_ff <= `SMC_CTRL_RST;
         preset_ff <= `SMC_PRESET_RST;
         status_ff <= `SMC_STATUS_RST;
         rdata_ff <= 8'h00;
         busy_ff <= 1'b0;
         st_ff <= smc_pkg::SMC_IDLE;
         cnt_ff <= 8'h00;
         xcnt_ff <= 5'h00;
         step_ff <= 2'h0;
         scl_drv_ff <= 1'b0;
         sda_drv_ff <= 1'b0;
         bytes_ff <= 1'b0;
         ft_cnt_ff <= 9'h000;
         ft_rolls_ff <= 4'h0;
         idle_cnt_ff <= 11'h000;
         irq_ff <= 1'b0;
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         start_sent_ff <= 1'b0;
         sim_stop_ff <= 1'b0;
         master_ff <= 1'b0;
         lt_reload_ff <= 1'b0;
         lt_count_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         preset_ff <= nxt_preset;
         status_ff <= nxt_status;
         rdata_ff <= nxt_rdata;
         busy_ff <= nxt_busy;
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         xcnt_ff <= nxt_xcnt;
         step_ff <= nxt_step;
         scl_drv_ff <= nxt_scl_drv;
         sda_drv_ff <= nxt_sda_drv;
         bytes_ff <= nxt_bytes;
         ft_cnt_ff <= nxt_ft_cnt;
         ft_rolls_ff <= nxt_ft_rolls;
         idle_cnt_ff <= nxt_idle_cnt;
         irq_ff <= nxt_irq;
         scl_oe_ff <= nxt_scl_oe;
         sda_oe_ff <= nxt_sda_oe;
         start_sent_ff <= nxt_start_sent;
         sim_stop_ff <= nxt_sim_stop;
         master_ff <= nxt_master;
         lt_reload_ff <= nxt_lt_reload;
         lt_count_ff <= nxt_lt_count;
      end
   end

   assign o_sfr_rdata = rdata_ff;
   assign o_irq = irq_ff;
   assign o_scl = 1'b0;
   assign o_scl_oe = scl_oe_ff;
   assign o_sda = 1'b0;
   assign o_sda_oe = sda_oe_ff;
   assign o_iface_enable = ctrl_ff[`SMC_BIT_EN];
   assign o_master = master_ff;
   assign o_start_sent = start_sent_ff;
   assign o_sim_stop = sim_stop_ff;
   assign o_addr_match_en = ctrl_ff[`SMC_BIT_ACK];
   assign o_lt_reload = lt_reload_ff;
   assign o_lt_count = lt_count_ff;
endmodule

// [testbench/smc_ctrl_props.sv]
// checker for the control and clock-rate logic
`timescale 1ns/10ps
module smc_ctrl_props (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // register port
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic i_sfr_bit_wr,
   // events and interrupt
   input wire logic i_state_event,
   input wire logic [7:0] i_state_code,
   input wire logic i_irq_en,
   input wire logic o_irq,
   // bus and engine side
   input wire logic o_scl_oe,
   input wire logic o_sda_oe,
   input wire logic i_ack_slot,
   input wire logic i_addressed,
   input wire logic o_iface_enable,
   input wire logic o_master,
   input wire logic o_start_sent,
   input wire logic o_sim_stop,
   input wire logic o_addr_match_en,
   input wire logic o_lt_reload,
   input wire logic o_lt_count
);
   logic ctl_wr;
   logic [7:0] preset_ff;
   logic [8:0] low_ff;
   assign ctl_wr = (i_sfr_wr | i_sfr_bit_wr) & (i_sfr_addr == 8'hC0);
   // shadow of the preset, so low phases are judged against the live value
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         preset_ff <= 8'h00;
         low_ff <= 9'h000;
      end else begin
         if (i_sfr_wr && i_sfr_addr == 8'hCF) begin
            preset_ff <= i_sfr_wdata;
         end
         low_ff <= o_scl_oe ? low_ff + 9'h001 : 9'h000;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   property p_si_irq;
      i_state_event && i_state_code != 8'hF8 && o_iface_enable && i_irq_en ##1 i_irq_en
         |=> o_irq;
   endproperty
   a_si_irq: assert property (p_si_irq) else $error("no irq after event");
   property p_si_hold;
      o_irq && i_irq_en && !$past(ctl_wr) |=> o_irq;
   endproperty
   a_si_hold: assert property (p_si_hold) else $error("flag dropped alone");
   property p_irq_off;
      !i_irq_en |=> !o_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while masked");
   property p_release;
      (!o_iface_enable)[*3] |-> !o_scl_oe && !o_sda_oe && !o_master;
   endproperty
   a_release: assert property (p_release) else $error("lines held when off");
   property p_start;
      o_start_sent |-> o_sda_oe ##1 o_scl_oe;
   endproperty
   a_start: assert property (p_start) else $error("bad start shape");
   property p_low;
      $fell(o_scl_oe) && o_master && o_iface_enable |-> low_ff >= 9'h100 - preset_ff;
   endproperty
   a_low: assert property (p_low) else $error("scl low too short");
   property p_ack;
      (i_ack_slot && i_addressed && o_addr_match_en && o_iface_enable && !o_master)[*3]
         |-> o_sda_oe;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack driven");
   property p_nack;
      (i_ack_slot && !o_addr_match_en && !o_master)[*2] |-> !o_sda_oe;
   endproperty
   a_nack: assert property (p_nack) else $error("ack with flag off");
   property p_sim;
      o_sim_stop |-> !o_master;
   endproperty
   a_sim: assert property (p_sim) else $error("slave halt as master");
   property p_lt;
      !(o_lt_reload && o_lt_count);
   endproperty
   a_lt: assert property (p_lt) else $error("reload and count together");
   c_start: cover property (o_start_sent);
   c_sim: cover property (o_sim_stop);
   c_stretch: cover property (o_irq && o_scl_oe);
endmodule

bind smc_ctrl smc_ctrl_props i_props (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
   .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
   .i_sfr_bit_wr(i_sfr_bit_wr), .i_state_event(i_state_event), .i_state_code(i_state_code),
   .i_irq_en(i_irq_en), .o_irq(o_irq), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe),
   .i_ack_slot(i_ack_slot), .i_addressed(i_addressed), .o_iface_enable(o_iface_enable),
   .o_master(o_master), .o_start_sent(o_start_sent), .o_sim_stop(o_sim_stop),
   .o_addr_match_en(o_addr_match_en), .o_lt_reload(o_lt_reload), .o_lt_count(o_lt_count));

// [testbench/smc_bus_peer.sv]
// behavioural model of another device on the two-wire bus
`timescale 1ns/10ps
module smc_bus_peer (
   // clock
   input wire logic i_core_clk,
   // device pull-downs
   input wire logic i_dut_scl_oe,
   input wire logic i_dut_sda_oe,
   // wired-and bus levels
   output logic o_scl,
   output logic o_sda
);
   logic pull_scl = 1'b0;
   logic pull_sda = 1'b0;
   // pull-ups: a released line reads high
   assign o_scl = !(i_dut_scl_oe || pull_scl);
   assign o_sda = !(i_dut_sda_oe || pull_sda);
   // one step is half of a 320 ns bus period
   task automatic step(input logic c, input logic d);
      @(posedge i_core_clk);
      pull_scl <= c;
      pull_sda <= d;
      repeat (3) @(posedge i_core_clk);
   endtask
   task automatic start();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
   endtask
   task automatic stop();
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      step(1'b0, 1'b0);
   endtask
   // leaves with no stop, so only the idle timer frees the bus
   task automatic abandon();
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
endmodule

// [testbench/test_smc_ctrl.sv]
// self-checking bench for the control and clock-rate logic
`timescale 1ns/10ps
module test_smc_ctrl;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] code = 8'h00;
   logic [2:0] bsel = 3'h0;
   logic wr = 1'b0;
   logic bwr = 1'b0;
   logic bval = 1'b0;
   logic rd = 1'b0;
   logic irq_en = 1'b0;
   logic ev = 1'b0;
   logic bdone = 1'b0;
   logic ack_slot = 1'b0;
   logic addressed = 1'b0;
   logic rd_q = 1'b0;
   logic scl_d = 1'b1;
   logic sda_d = 1'b1;
   logic [7:0] rdata;
   logic irq, scl, sda, scl_oe, sda_oe, en, mst, st_sent, sim_stop, am_en, lt_rl, lt_ct;
   logic [31:0] seed = 32'hF96D;
   logic [7:0] exp_q[$];
   string nam_q[$];
   int fails = 0;
   int checks_done = 0;
   // idle and free-timer counts shortened to keep the run brief
   // idle count kept above one scl high phase, so it never frees a live transfer
   smc_ctrl #(.BUS_IDLE_CYC(60), .FREE_ROLLS(2)) i_dut (
      .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_sfr_addr(addr), .i_sfr_wr(wr),
      .i_sfr_wdata(wdata), .i_sfr_bit_wr(bwr), .i_sfr_bit_sel(bsel), .i_sfr_bit_val(bval),
      .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_irq_en(irq_en), .o_irq(irq),
      .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(), .o_sda_oe(sda_oe),
      .i_state_event(ev), .i_state_code(code), .i_byte_done(bdone), .i_arb_lost(1'b0),
      .i_data_low(1'b0), .i_ack_slot(ack_slot), .i_addressed(addressed),
      .o_iface_enable(en), .o_master(mst), .o_start_sent(st_sent), .o_sim_stop(sim_stop),
      .o_addr_match_en(am_en), .o_lt_reload(lt_rl), .o_lt_count(lt_ct));
   smc_bus_peer i_peer (.i_core_clk(i_core_clk), .i_dut_scl_oe(scl_oe),
      .i_dut_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
   always #20 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      rd_q <= rd;
      scl_d <= scl;
      sda_d <= sda;
   end
   // read data is settled by the falling edge after the read
   always @(negedge i_core_clk) begin
      if (rd_q) begin
         chk(nam_q.pop_front(), exp_q.pop_front(), rdata);
      end
   end
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic print_verdict();
      if (fails == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_core_clk);
      wr <= 1'b0;
   endtask
   task automatic sfr_bit(input logic [2:0] s, input logic v);
      @(posedge i_core_clk);
      addr <= 8'hC0;
      bsel <= s;
      bval <= v;
      bwr <= 1'b1;
      @(posedge i_core_clk);
      bwr <= 1'b0;
   endtask
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge i_core_clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      nam_q.push_back(n);
      @(posedge i_core_clk);
      rd <= 1'b0;
   endtask
   task automatic event_in(input logic [7:0] c);
      @(posedge i_core_clk);
      ev <= 1'b1;
      code <= c;
      @(posedge i_core_clk);
      ev <= 1'b0;
   endtask
   // bounded wait: 0 start sent, 1 stop on wire, 2 slave halt, 3 scl freed, 4 scl pulled
   task automatic wait_for(input int s, output int cyc);
      logic hit;
      cyc = 0;
      hit = 1'b0;
      while (!hit) begin
         @(negedge i_core_clk);
         cyc++;
         case (s)
            0: hit = st_sent;
            1: hit = scl && scl_d && sda && !sda_d;
            2: hit = sim_stop;
            3: hit = !scl_oe;
            default: hit = scl_oe;
         endcase
         if (cyc > 300) begin
            fails++;
            $display("MISMATCH wait_%0d exp 1 got 0", s);
            print_verdict();
         end
      end
   endtask
   initial begin
      int cyc;
      logic [7:0] r;
      tick(10);
      i_nrst <= 1'b1;
      sfr_rd(8'hC0, 8'h00, "ctrl_rst");
      sfr_rd(8'hC1, 8'hF8, "status_rst");
      sfr_rd(8'hCF, 8'h00, "preset_rst");
      sfr_rd(8'hC5, 8'h00, "unmapped");
      sfr_wr(8'hC0, 8'h86);
      event_in(8'h08);
      sfr_rd(8'hC0, 8'h06, "busy_ro_off");
      chk("addr_match", 8'h01, {7'h00, am_en});
      sfr_wr(8'hC0, 8'h44);
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         if ((r & 8'hF8) == 8'hF8) begin
            r = 8'h08;
         end
         @(posedge i_core_clk);
         irq_en <= i[0];
         event_in(r);
         tick(10);
         @(negedge i_core_clk);
         chk("irq", {7'h00, irq_en}, {7'h00, irq});
         sfr_rd(8'hC1, r & 8'hF8, "status");
         sfr_rd(8'hC0, 8'h4C, "ctrl_si");
         sfr_bit(3'h3, 1'b0);
      end
      event_in(8'hF8);
      tick(3);
      sfr_rd(8'hC0, 8'h44, "idle_code");
      sfr_wr(8'hCF, 8'hF0);
      sfr_rd(8'hCF, 8'hF0, "preset");
      sfr_bit(3'h5, 1'b1);
      wait_for(0, cyc);
      wait_for(3, cyc);
      chk("scl_low", 8'h10, 8'(cyc - 1));
      wait_for(4, cyc);
      chk("scl_high", 8'h01, {7'h00, cyc >= 34 && cyc <= 40});
      event_in(8'h28);
      tick(30);
      chk("stretch", 8'h01, {7'h00, scl_oe});
      sfr_bit(3'h5, 1'b0);
      sfr_bit(3'h3, 1'b0);
      @(posedge i_core_clk);
      bdone <= 1'b1;
      @(posedge i_core_clk);
      bdone <= 1'b0;
      sfr_bit(3'h5, 1'b1);
      wait_for(0, cyc);
      sfr_bit(3'h5, 1'b0);
      sfr_wr(8'hC0, 8'h74);
      wait_for(1, cyc);
      wait_for(0, cyc);
      sfr_wr(8'hC0, 8'h54);
      wait_for(1, cyc);
      tick(4);
      sfr_rd(8'hC0, 8'h44, "halt_cleared");
      i_peer.start();
      sfr_bit(3'h5, 1'b1);
      tick(30);
      chk("wait_free", 8'h00, {7'h00, sda_oe});
      i_peer.stop();
      wait_for(0, cyc);
      chk("start_delay", 8'h01, {7'h00, cyc >= 16});
      sfr_wr(8'hC0, 8'h55);
      wait_for(1, cyc);
      tick(4);
      i_peer.start();
      sfr_bit(3'h4, 1'b1);
      wait_for(2, cyc);
      tick(2);
      sfr_rd(8'hC0, 8'hC5, "busy_kept");
      chk("lt_count", 8'h01, {7'h00, lt_ct});
      i_peer.abandon();
      tick(70);
      sfr_rd(8'hC0, 8'h45, "idle_free");
      chk("lt_reload", 8'h01, {7'h00, lt_rl});
      @(posedge i_core_clk);
      ack_slot <= 1'b1;
      addressed <= 1'b1;
      tick(3);
      chk("ack_drive", 8'h01, {7'h00, sda_oe});
      sfr_bit(3'h2, 1'b0);
      tick(3);
      chk("nack", 8'h00, {7'h00, sda_oe});
      chk("addr_ignored", 8'h00, {7'h00, am_en});
      ack_slot <= 1'b0;
      sfr_wr(8'hC0, 8'h64);
      wait_for(0, cyc);
      sfr_wr(8'hC0, 8'h00);
      tick(4);
      chk("released", 8'h00, {6'h00, scl_oe, sda_oe});
      chk("master_off", 8'h00, {7'h00, mst});
      sfr_rd(8'hC0, 8'h00, "ctrl_off");
      tick(3);
      print_verdict();
   end
endmodule
